// ---- rtl/uieid_pkg.sv ----
// Package: register offsets, field positions and codes of the interrupt enable/identify logic
package uieid_pkg;
  localparam logic [2:0] UIEID_OFS_ENABLE = 3'h1;
  localparam logic [2:0] UIEID_OFS_IDENT = 3'h2;
  localparam logic [2:0] UIEID_OFS_RXBUF = 3'h0;
  localparam logic [2:0] UIEID_OFS_LSR = 3'h5;
  localparam logic [2:0] UIEID_OFS_MSR = 3'h6;
  localparam int UIEID_BIT_RXDATA = 0;
  localparam int UIEID_BIT_TXEMPTY = 1;
  localparam int UIEID_BIT_LINE = 2;
  localparam int UIEID_BIT_MODEM = 3;
  localparam logic [3:0] UIEID_ENABLE_RESET = 4'h0;
  localparam logic [2:0] UIEID_CODE_LINE = 3'h3;
  localparam logic [2:0] UIEID_CODE_RXDATA = 3'h2;
  localparam logic [2:0] UIEID_CODE_TIMEOUT = 3'h6;
  localparam logic [2:0] UIEID_CODE_TXEMPTY = 3'h1;
  localparam logic [2:0] UIEID_CODE_MODEM = 3'h0;
  localparam logic [7:0] UIEID_IDENT_RESET = 8'h01;
  localparam logic [1:0] UIEID_FIFO_BITS_ON = 2'h3;
  typedef struct packed {
    logic line;
    logic rxdata;
    logic timeout;
    logic txempty;
    logic modem;
  } uieid_src_t;
endpackage : uieid_pkg

// ---- rtl/uieid_prio.sv ----
// Priority encoder for the identification code
`timescale 1ns/10ps
module uieid_prio import uieid_pkg::*; (
  // Source side
  uieid_src_if.enc s
);
  logic line_on;
  logic rx_on;
  logic to_on;
  logic tx_on;
  logic ms_on;
  always_comb begin
    line_on = s.pending.line & s.enable[UIEID_BIT_LINE];                    // [R4] [R22]
    rx_on = s.pending.rxdata & s.enable[UIEID_BIT_RXDATA];                   // [R6]
    to_on = s.pending.timeout & s.enable[UIEID_BIT_RXDATA] & s.fifo_mode;    // [R6] [R11]
    tx_on = s.pending.txempty & s.enable[UIEID_BIT_TXEMPTY];                 // [R5]
    ms_on = s.pending.modem & s.enable[UIEID_BIT_MODEM];                     // [R3]
    s.any = line_on | rx_on | to_on | tx_on | ms_on;                         // [R2]
    if (line_on) begin
      s.code = UIEID_CODE_LINE;                                              // [R12]
    end else if (rx_on) begin
      s.code = UIEID_CODE_RXDATA;                                            // [R13]
    end else if (to_on) begin
      s.code = UIEID_CODE_TIMEOUT;                                           // [R15]
    end else if (tx_on) begin
      s.code = UIEID_CODE_TXEMPTY;                                           // [R16]
    end else begin
      s.code = UIEID_CODE_MODEM;                                             // [R17]
    end
  end
endmodule : uieid_prio

// ---- rtl/uieid_src_if.sv ----
// Interface: pending sources and enables between the top and the priority encoder
`timescale 1ns/10ps
interface uieid_src_if;
  import uieid_pkg::*;
  uieid_src_t pending;
  logic [3:0] enable;
  logic fifo_mode;
  logic [2:0] code;
  logic any;
  modport top (output pending, output enable, output fifo_mode, input code, input any);
  modport enc (input pending, input enable, input fifo_mode, output code, output any);
endinterface : uieid_src_if

// ---- rtl/uieid_top.sv ----
// Interrupt enable and identification logic of the serial port
// Behaviour
// R1: Enable register at offset 1, bits 7..4 read zero, bits 3..0 gate sources.
// R2: All enables zero means no interrupt; each bit permits only its class.
// R3: Enable bit 3 permits modem status interrupt on modem line changes.
// R4: Enable bit 2 permits receiver line status interrupt on errors or break.
// R5: Enable bit 1 permits transmitter holding empty interrupt.
// R6: Enable bit 0 permits received data, and FIFO trigger and timeout.
// R7: Identification register at offset 2 is read-only, frozen while read.
// R8: Events during identification read are captured, shown after read ends.
// R9: Bits 7,6 show FIFO mode, zero on non-FIFO variant; bits 5,4 zero.
// R10: Bit 0 is active low pending flag; code valid only when zero.
// R11: Bit 3 reads zero outside FIFO mode.
// R12: Line status highest priority, code 011, cleared by line status read.
// R13: Received data second, code 010, cleared by buffer read or trigger level.
// R14: FIFO trigger interrupt drops when fill falls below trigger level.
// R15: Character timeout code 110, second priority, cleared by FIFO read.
// R16: Transmit empty third, code 001, cleared by ident read or transmit write.
// R17: Modem status lowest, code 000, raised by modem line changes.
// R18: Modem status stays pending until modem status register is read.
// R19: Board interrupt reaches host only while user output two is set.
// R20: After reset FIFO mode off, so bits 7, 6 and 3 read zero.
// R21: Interrupt output active when any source is enabled and pending.
// R22: Disabled source is not reported; lower enabled source may show.
`timescale 1ns/10ps
module uieid_top import uieid_pkg::*; #(
  parameter bit HAS_FIFO = 1'b1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host register access
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_dlab,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Source conditions from the rest of the port
  input wire logic i_line_event,
  input wire logic i_rx_ready,
  input wire logic i_rx_trigger,
  input wire logic i_rx_timeout,
  input wire logic i_tx_empty,
  input wire logic i_modem_change,
  input wire logic i_fifo_mode,
  input wire logic i_user_output_two,
  // Interrupt outputs
  output logic o_irq,
  output logic o_irq_board
);
  // ****************************************
  // State
  // ****************************************
  logic [3:0] enable_reg;
  logic [3:0] enable_next;
  logic line_reg;
  logic line_next;
  logic modem_reg;
  logic modem_next;
  logic tx_reg;
  logic tx_next;
  logic tx_empty_d_reg;
  logic tx_empty_d_next;
  logic rd_d_reg;
  logic rd_d_next;
  logic [7:0] ident_reg;
  logic [7:0] ident_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic board_reg;
  logic board_next;
  logic fifo_on;
  logic ident_rd;
  uieid_src_if src ();

  uieid_prio u_prio (
    .s(src)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Strobe qualified by a register offset
  function automatic logic bus_hit(input logic strobe, input logic [2:0] addr, input logic [2:0] ofs);
    return strobe && (addr == ofs);
  endfunction : bus_hit

  // Encoder inputs kept out of the next-state process, which reads the code back
  assign fifo_on = HAS_FIFO & i_fifo_mode;                                    // [R20]
  // Data ready and trigger are level conditions owned by the receiver
  assign src.pending = '{line: line_reg,
                         rxdata: fifo_on ? i_rx_trigger : i_rx_ready,         // [R13] [R14]
                         timeout: i_rx_timeout,                               // [R15]
                         txempty: tx_reg & i_tx_empty,
                         modem: modem_reg};                                   // [R3]
  assign src.enable = enable_reg;
  assign src.fifo_mode = fifo_on;

  always_comb begin
    ident_rd = bus_hit(i_rd, i_addr, UIEID_OFS_IDENT);
    enable_next = enable_reg;
    if (bus_hit(i_wr && !i_dlab, i_addr, UIEID_OFS_ENABLE)) begin
      enable_next = i_wdata[3:0];                                             // [R1]
    end
    // Set wins over a same-cycle clear
    line_next = i_line_event | (line_reg & ~bus_hit(i_rd, i_addr, UIEID_OFS_LSR));     // [R12] [R4]
    modem_next = i_modem_change | (modem_reg & ~bus_hit(i_rd, i_addr, UIEID_OFS_MSR)); // [R18] [R17]
    // Empty is flagged on its rising edge and by enabling the source
    tx_empty_d_next = i_tx_empty;
    tx_next = tx_reg;
    // Only the first cycle of a read clears, so an event during a long read survives
    if (ident_rd && !rd_d_reg && ident_reg[3:1] == UIEID_CODE_TXEMPTY && !ident_reg[0]) begin
      tx_next = 1'b0;                                                         // [R16] [R8]
    end
    if (bus_hit(i_wr && !i_dlab, i_addr, UIEID_OFS_RXBUF)) begin
      tx_next = 1'b0;                                                         // [R16]
    end
    if ((i_tx_empty && !tx_empty_d_reg)
        || (i_tx_empty && enable_next[UIEID_BIT_TXEMPTY] && !enable_reg[UIEID_BIT_TXEMPTY])) begin
      tx_next = 1'b1;
    end
    rd_d_next = ident_rd;
    // Snapshot held while the read lasts; new events shown afterwards
    ident_next = ident_reg;
    if (!ident_rd) begin
      ident_next = {fifo_on ? UIEID_FIFO_BITS_ON : 2'h0, 2'h0,
                    src.code[2] & fifo_on, src.code[1:0], ~src.any};          // [R7] [R8] [R9] [R10] [R11]
    end
    rdata_next = 8'h00;
    if (i_rd) begin
      if (i_addr == UIEID_OFS_IDENT) begin
        rdata_next = ident_reg;                                               // [R7]
      end else if (i_addr == UIEID_OFS_ENABLE && !i_dlab) begin
        rdata_next = {4'h0, enable_reg};                                      // [R1]
      end
    end
    irq_next = src.any;                                                       // [R21] [R2]
    board_next = src.any & i_user_output_two;                                 // [R19]
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enable_reg <= UIEID_ENABLE_RESET;
      line_reg <= 1'b0;
      modem_reg <= 1'b0;
      tx_reg <= 1'b0;
      // Idle level of an empty transmitter, so no false edge after reset
      tx_empty_d_reg <= 1'b1;
      rd_d_reg <= 1'b0;
      ident_reg <= UIEID_IDENT_RESET;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      board_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      line_reg <= line_next;
      modem_reg <= modem_next;
      tx_reg <= tx_next;
      tx_empty_d_reg <= tx_empty_d_next;
      rd_d_reg <= rd_d_next;
      ident_reg <= ident_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      board_reg <= board_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq = irq_reg;
  assign o_irq_board = board_reg;
endmodule : uieid_top

// ---- verification/uart_interrupt_enable_identify_bench.sv ----
// Self-checking bench of the interrupt enable and identify logic
`timescale 1ns/10ps
module uart_interrupt_enable_identify_bench;
  import uieid_pkg::*;
  logic clk = 1'b0, rst = 1'b1, line = 1'b0, rxr = 1'b0, trg = 1'b0, tmo = 1'b0;
  logic txe = 1'b0, mdm = 1'b0, fifo = 1'b0, uo2 = 1'b0, dlab = 1'b0;
  logic [2:0] addr;
  logic rd, wr, irq, irqb;
  logic [7:0] wdata, rdata, rdata_p;
  int n_errors = 0, check_count = 0, cyc = 0;
  uieid_top #(.HAS_FIFO(1'b1)) i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_dlab(dlab),
    .i_wdata(wdata), .o_rdata(rdata), .i_line_event(line), .i_rx_ready(rxr), .i_rx_trigger(trg),
    .i_rx_timeout(tmo), .i_tx_empty(txe), .i_modem_change(mdm), .i_fifo_mode(fifo),
    .i_user_output_two(uo2), .o_irq(irq), .o_irq_board(irqb));
  uieid_host i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  // Variant without FIFOs on the same stimulus
  uieid_top #(.HAS_FIFO(1'b0)) i_dut_plain (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_rd(rd), .i_wr(wr),
    .i_dlab(dlab), .i_wdata(wdata), .o_rdata(rdata_p), .i_line_event(line), .i_rx_ready(rxr), .i_rx_trigger(trg),
    .i_rx_timeout(tmo), .i_tx_empty(txe), .i_modem_change(mdm), .i_fifo_mode(fifo),
    .i_user_output_two(uo2), .o_irq(), .o_irq_board());
  // ****
  // Clock, timeout and tasks
  // ****
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      $display("[ERR] %0t timeout", $time);
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input int n = 1);
    logic [7:0] d;
    i_host.rd_reg(a, n, d);
    cmp(d, e);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // ****
  // Tests
  // ****
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rdc(UIEID_OFS_IDENT, UIEID_IDENT_RESET);
    rdc(UIEID_OFS_ENABLE, 8'h00);
    i_host.wr_reg(UIEID_OFS_ENABLE, 8'hFF);
    rdc(UIEID_OFS_ENABLE, 8'h0F);
    i_host.wr_reg(UIEID_OFS_ENABLE, 8'h00);
    txe = 1'b1;
    rxr = 1'b1;
    pulse(line);
    pulse(mdm);
    idle(3);
    cmp({7'h0, irq}, 8'h00);
    rdc(UIEID_OFS_IDENT, 8'h01);
    i_host.wr_reg(UIEID_OFS_ENABLE, 8'h08);
    pulse(mdm);
    idle(3);
    rdc(UIEID_OFS_IDENT, 8'h00);
    cmp({7'h0, irqb}, 8'h00);
    uo2 = 1'b1;
    idle(3);
    cmp({irq, irqb, 6'h0}, 8'hC0);
    rdc(UIEID_OFS_MSR, 8'h00);
    idle(2);
    rdc(UIEID_OFS_IDENT, 8'h01);
    i_host.wr_reg(UIEID_OFS_ENABLE, 8'h0F);
    pulse(line);
    pulse(mdm);
    idle(3);
    rdc(UIEID_OFS_IDENT, 8'h06);
    rdc(UIEID_OFS_LSR, 8'h00);
    idle(2);
    rdc(UIEID_OFS_IDENT, 8'h04);
    rxr = 1'b0;
    idle(3);
    fork
      rdc(UIEID_OFS_IDENT, 8'h02, 2);
      begin
        idle(1);
        pulse(line);
      end
    join
    idle(2);
    rdc(UIEID_OFS_IDENT, 8'h06);
    rdc(UIEID_OFS_LSR, 8'h00);
    idle(2);
    rdc(UIEID_OFS_IDENT, 8'h00);
    rdc(UIEID_OFS_MSR, 8'h00);
    idle(2);
    rdc(UIEID_OFS_IDENT, 8'h01);
    fifo = 1'b1;
    tmo = 1'b1;
    idle(3);
    fork
      rdc(UIEID_OFS_IDENT, 8'hCC);
      begin
        idle(1);
        cmp(rdata_p, 8'h01);
      end
    join
    tmo = 1'b0;
    trg = 1'b1;
    idle(3);
    rdc(UIEID_OFS_IDENT, 8'hC4);
    trg = 1'b0;
    idle(3);
    rdc(UIEID_OFS_IDENT, 8'hC1);
    fifo = 1'b0;
    tmo = 1'b1;
    idle(3);
    rdc(UIEID_OFS_IDENT, 8'h01);
    // Divisor latch access hides the enable and transmit registers
    dlab = 1'b1;
    i_host.wr_reg(UIEID_OFS_ENABLE, 8'h00);
    rdc(UIEID_OFS_ENABLE, 8'h00);
    txe = 1'b0;
    idle(1);
    txe = 1'b1;
    idle(3);
    i_host.wr_reg(UIEID_OFS_RXBUF, 8'h5A);
    cmp({7'h0, irq}, 8'h01);
    dlab = 1'b0;
    rdc(UIEID_OFS_ENABLE, 8'h0F);
    i_host.wr_reg(UIEID_OFS_RXBUF, 8'h5A);
    idle(2);
    cmp({7'h0, irq}, 8'h00);
    rdc(UIEID_OFS_IDENT, 8'h01);
    give_verdict();
  end
endmodule : uart_interrupt_enable_identify_bench

// ---- verification/uieid_host.sv ----
// Host processor model issuing register cycles
`timescale 1ns/10ps
module uieid_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [2:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // ****
  // Bus cycles, launched after a falling edge
  // ****
  initial begin
    o_addr = 3'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Stale data inverted so nothing relies on a held bus
    o_wdata = ~d;
    @(negedge i_clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input int n, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    repeat (n) @(negedge i_clk);
    d = i_rdata;
    o_rd = 1'b0;
    @(negedge i_clk);
  endtask : rd_reg
endmodule : uieid_host

// ---- verification/uieid_monitor.sv ----
// Checker of the interrupt enable and identify ports
`timescale 1ns/10ps
module uieid_monitor import uieid_pkg::*; #(parameter bit HAS_FIFO = 1'b1) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_dlab,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_fifo_mode,
  input wire logic i_user_output_two,
  input wire logic o_irq,
  input wire logic o_irq_board
);
  // ****
  // Properties
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire ird = i_rd && i_addr == UIEID_OFS_IDENT;
  wire ern = i_rd && !i_dlab && i_addr == UIEID_OFS_ENABLE;
  sequence s_en_wr; i_wr && !i_dlab && i_addr == UIEID_OFS_ENABLE; endsequence
  sequence s_id_start; ird && !$past(i_rd); endsequence
  a_en_upper_zero: assert property (ern |=> o_rdata[7:4] == 4'h0)
    else $error("Enable upper bits set");
  a_en_read_back: assert property (s_en_wr ##1 !i_wr ##1 ern |=> o_rdata == ($past(i_wdata, 3) & 8'h0F))
    else $error("Enable read back wrong");
  a_all_off_quiet: assert property (s_en_wr ##0 i_wdata[3:0] == 4'h0 ##1 (!i_wr)[*3] |-> !o_irq)
    else $error("Interrupt with all enables off");
  a_nofifo_bits_zero: assert property (s_id_start ##0 !i_fifo_mode && !$past(i_fifo_mode) && !$past(i_fifo_mode, 2)
    |=> o_rdata[7:3] == 5'h0)
    else $error("Ident upper bits set outside FIFO mode");
  a_fifo_bits_on: assert property (s_id_start ##0 i_fifo_mode && $past(i_fifo_mode) && $past(i_fifo_mode, 2)
    |=> o_rdata[7:6] == {HAS_FIFO, HAS_FIFO})
    else $error("FIFO mode bits wrong");
  a_board_gate_off: assert property (!$past(i_user_output_two) |-> !o_irq_board)
    else $error("Board interrupt without user output two");
  a_ident_frozen: assert property (ird && $past(ird) |=> $stable(o_rdata))
    else $error("Ident changed during read");
  a_reset_ident: assert property ($past(i_rst) && ird |=> o_rdata == UIEID_IDENT_RESET)
    else $error("Ident wrong after reset");
endmodule : uieid_monitor
bind uieid_top uieid_monitor #(.HAS_FIFO(HAS_FIFO)) u_mon (.i_clk, .i_rst, .i_addr, .i_rd, .i_wr, .i_dlab,
  .i_wdata, .o_rdata, .i_fifo_mode, .i_user_output_two, .o_irq, .o_irq_board);
